// >>> rtl/sbrg_top.sv
// Purpose: Serial bit-rate generator with AXI4-Lite registers
// Assumes: clk is the system oscillator; rx_pin is asynchronous
// Notes:   One write and one read in flight at a time
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`include "sbrg_defs.svh"
`default_nettype none

module sbrg_top
    import sbrg_pkg::*;
#(
    parameter int ADDR_W = `SBRG_ADDR_W,
    parameter int CNT_W  = `SBRG_CNT_W
)
(
    input  wire logic              clk,      // System clock
    input  wire logic              nrst,     // Async reset, active low
    input  wire logic [ADDR_W-1:0] awaddr,   // Write address
    input  wire logic              awvalid,  // Write address valid
    output logic                   awready,  // Write address ready
    input  wire logic [31:0]       wdata,    // Write data
    input  wire logic [3:0]        wstrb,    // Write byte strobes
    input  wire logic              wvalid,   // Write data valid
    output logic                   wready,   // Write data ready
    output logic [1:0]             bresp,    // Write response
    output logic                   bvalid,   // Write response valid
    input  wire logic              bready,   // Write response ready
    input  wire logic [ADDR_W-1:0] araddr,   // Read address
    input  wire logic              arvalid,  // Read address valid
    output logic                   arready,  // Read address ready
    output logic [31:0]            rdata,    // Read data
    output logic [1:0]             rresp,    // Read response
    output logic                   rvalid,   // Read data valid
    input  wire logic              rready,   // Read data ready
    input  wire logic              rx_pin,   // Receive pin
    output logic                   rx_level, // Voted receive level
    output logic                   bit_tick, // Bit period pulse
    output logic                   sub_tick, // Divider wrap pulse
    output logic                   sync_mode // Synchronous selected
);

    // -----------------------------------------------------------
    // State
    // -----------------------------------------------------------
    typedef struct packed {
        logic              rx_m;
        logic              rx_s;
        logic [7:0]        tsc;
        logic [7:0]        rsc;
        logic [7:0]        rctl;
        logic [7:0]        div_hi;
        logic [7:0]        div_lo;
        logic              div_clr;
        logic              awready;
        logic              wready;
        logic              aw_have;
        logic              w_have;
        logic [ADDR_W-1:0] waddr;
        logic [7:0]        wbyte;
        logic              wlane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } sbrg_top_s;

    sbrg_top_s        s_r;
    sbrg_top_s        s_nxt;
    logic [CNT_W-1:0] divisor;
    logic [CNT_W-1:0] count;
    sbrg_ratio_e      ratio;
    logic             vote_level;

    // -----------------------------------------------------------
    // Decode helpers
    // -----------------------------------------------------------
    function automatic logic [7:0] word_addr(
        input logic [ADDR_W-1:0] a
    );
        word_addr = {a[7:2], 2'b00};
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `SBRG_OFF_TSC)    ||
                    (a == `SBRG_OFF_RSC)    ||
                    (a == `SBRG_OFF_RCTL)   ||
                    (a == `SBRG_OFF_DIV_HI) ||
                    (a == `SBRG_OFF_DIV_LO) ||
                    (a == `SBRG_OFF_STATUS);
    endfunction

    function automatic logic [7:0] merge(
        input logic [7:0] old_v,
        input logic [7:0] new_v,
        input logic [7:0] mask
    );
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    function automatic sbrg_ratio_e pick_ratio(
        input logic sync_sel,
        input logic wide_sel,
        input logic hsps_sel
    );
        if (sync_sel) begin
            pick_ratio = SBRG_DIV4;
        end else if (wide_sel && hsps_sel) begin
            pick_ratio = SBRG_DIV4;
        end else if (wide_sel || hsps_sel) begin
            pick_ratio = SBRG_DIV16;
        end else begin
            pick_ratio = SBRG_DIV64;
        end
    endfunction

    function automatic logic [31:0] read_word(
        input logic [7:0]       a,
        input sbrg_top_s        st,
        input logic             lvl,
        input logic [CNT_W-1:0] cnt
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            `SBRG_OFF_TSC:    v[7:0] = st.tsc;
            `SBRG_OFF_RSC:    v[7:0] = st.rsc;
            `SBRG_OFF_RCTL:   v[7:0] = st.rctl;
            `SBRG_OFF_DIV_HI: v[7:0] = st.div_hi;
            `SBRG_OFF_DIV_LO: v[7:0] = st.div_lo;
            `SBRG_OFF_STATUS: begin
                v[0]     = lvl;
                v[31:16] = cnt;
            end
            default:          v = 32'h0000_0000;
        endcase
        read_word = v;
    endfunction

    // -----------------------------------------------------------
    // Mode decode and divisor selection
    // -----------------------------------------------------------
    assign ratio = pick_ratio(s_r.tsc[`SBRG_BIT_SYNC],
                              s_r.rctl[`SBRG_BIT_WIDE],
                              s_r.tsc[`SBRG_BIT_HSPS]);

    // High byte ignored in 8-bit counting
    assign divisor = s_r.rctl[`SBRG_BIT_WIDE] ?
                     {s_r.div_hi, s_r.div_lo} :
                     {8'h00, s_r.div_lo};

    // -----------------------------------------------------------
    // Next state
    // -----------------------------------------------------------
    always_comb begin
        logic [7:0] wa;
        logic [7:0] ra;
        wa = word_addr(s_r.waddr);
        ra = word_addr(araddr);
        s_nxt = s_r;
        s_nxt.div_clr = 1'b0;

        // Receive pin synchroniser
        s_nxt.rx_m = rx_pin;
        s_nxt.rx_s = s_r.rx_m;

        // Write address channel
        if (awvalid && s_r.awready) begin
            s_nxt.waddr   = awaddr;
            s_nxt.aw_have = 1'b1;
            s_nxt.awready = 1'b0;
        end

        // Write data channel, only lane 0 carries register bits
        if (wvalid && s_r.wready) begin
            s_nxt.wbyte  = wdata[7:0];
            s_nxt.wlane0 = wstrb[0];
            s_nxt.w_have = 1'b1;
            s_nxt.wready = 1'b0;
        end

        // Perform write once both halves are held
        if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have  = 1'b0;
            s_nxt.bvalid  = 1'b1;
            s_nxt.bresp   = is_mapped(wa) ? `SBRG_RESP_OKAY :
                                            `SBRG_RESP_SLVERR;
            if (s_r.wlane0) begin
                unique case (wa)
                    `SBRG_OFF_TSC: begin
                        s_nxt.tsc = merge(s_r.tsc, s_r.wbyte,
                                          `SBRG_WMASK_TSC);
                    end
                    `SBRG_OFF_RSC: begin
                        s_nxt.rsc = merge(s_r.rsc, s_r.wbyte,
                                          `SBRG_WMASK_RSC);
                    end
                    `SBRG_OFF_RCTL: begin
                        s_nxt.rctl = merge(s_r.rctl, s_r.wbyte,
                                           `SBRG_WMASK_RCTL);
                    end
                    `SBRG_OFF_DIV_HI: begin
                        s_nxt.div_hi  = s_r.wbyte;
                        s_nxt.div_clr = 1'b1;
                    end
                    `SBRG_OFF_DIV_LO: begin
                        s_nxt.div_lo  = s_r.wbyte;
                        s_nxt.div_clr = 1'b1;
                    end
                    default: begin
                        s_nxt.div_clr = 1'b0;
                    end
                endcase
            end
        end

        // Write response; reopen channels after it is taken
        if (s_r.bvalid && bready) begin
            s_nxt.bvalid  = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready  = 1'b1;
        end

        // Read channel
        if (arvalid && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid  = 1'b1;
            s_nxt.rdata   = read_word(ra, s_r, vote_level, count);
            s_nxt.rresp   = is_mapped(ra) ? `SBRG_RESP_OKAY :
                                            `SBRG_RESP_SLVERR;
        end
        if (s_r.rvalid && rready) begin
            s_nxt.rvalid  = 1'b0;
            s_nxt.arready = 1'b1;
        end
    end

    // -----------------------------------------------------------
    // State register
    // -----------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r         <= '0;
            s_r.rx_m    <= `SBRG_RX_IDLE;
            s_r.rx_s    <= `SBRG_RX_IDLE;
            s_r.tsc     <= `SBRG_RST_TSC;
            s_r.rsc     <= `SBRG_RST_RSC;
            s_r.rctl    <= `SBRG_RST_RCTL;
            s_r.div_hi  <= `SBRG_RST_DIV;
            s_r.div_lo  <= `SBRG_RST_DIV;
            s_r.awready <= 1'b1;
            s_r.wready  <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.bresp   <= `SBRG_RESP_OKAY;
            s_r.rresp   <= `SBRG_RESP_OKAY;
        end else begin
            s_r <= s_nxt;
        end
    end

    // -----------------------------------------------------------
    // Divider and receive majority detector
    // -----------------------------------------------------------
    sbrg_divider #(
        .CNT_W    (CNT_W)
    ) u_div (
        .clk      (clk),
        .nrst     (nrst),
        .clear    (s_r.div_clr),
        .divisor  (divisor),
        .ratio    (ratio),
        .count    (count),
        .sub_tick (sub_tick),
        .bit_tick (bit_tick)
    );

    sbrg_vote u_vote (
        .clk      (clk),
        .nrst     (nrst),
        .sample   (sub_tick),
        .rx       (s_r.rx_s),
        .level    (vote_level)
    );

    // -----------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------
    assign awready   = s_r.awready;
    assign wready    = s_r.wready;
    assign bvalid    = s_r.bvalid;
    assign bresp     = s_r.bresp;
    assign arready   = s_r.arready;
    assign rvalid    = s_r.rvalid;
    assign rdata     = s_r.rdata;
    assign rresp     = s_r.rresp;
    assign rx_level  = vote_level;
    assign sync_mode = s_r.tsc[`SBRG_BIT_SYNC];

endmodule

`default_nettype wire

// >>> rtl/sbrg_defs.svh
// Purpose: Constants of the serial bit-rate generator
// Assumes: Included by every design file of the block except the package
// Notes:   Offsets are byte addresses on the register bus
`ifndef SBRG_DEFS_SVH
`define SBRG_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SBRG_OFF_TSC      8'h00
`define SBRG_OFF_RSC      8'h04
`define SBRG_OFF_RCTL     8'h08
`define SBRG_OFF_DIV_HI   8'h0C
`define SBRG_OFF_DIV_LO   8'h10
`define SBRG_OFF_STATUS   8'h14

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SBRG_BIT_SYNC     4
`define SBRG_BIT_HSPS     2
`define SBRG_BIT_TXIDLE   1
`define SBRG_BIT_WIDE     3
`define SBRG_BIT_RXIDLE   6

// ---------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------
`define SBRG_RST_TSC      8'h02
`define SBRG_RST_RSC      8'h00
`define SBRG_RST_RCTL     8'h40
`define SBRG_RST_DIV      8'h00
`define SBRG_WMASK_TSC    8'hFD
`define SBRG_WMASK_RSC    8'hF8
`define SBRG_WMASK_RCTL   8'h9B

// ---------------------------------------------------------------
// Prescale terminal counts (ratio minus one)
// ---------------------------------------------------------------
`define SBRG_TERM_4       6'h03
`define SBRG_TERM_16      6'h0F
`define SBRG_TERM_64      6'h3F

// ---------------------------------------------------------------
// Bus answers and widths
// ---------------------------------------------------------------
`define SBRG_RESP_OKAY    2'h0
`define SBRG_RESP_SLVERR  2'h2
`define SBRG_CNT_W        16
`define SBRG_ADDR_W       8
`define SBRG_RX_IDLE      1'b1

`endif

// >>> rtl/sbrg_pkg.sv
// Purpose: Shared types of the serial bit-rate generator
// Assumes: Nothing beyond the constants header
// Notes:   Ratio codes are Gray ordered
`default_nettype none

package sbrg_pkg;

    // -----------------------------------------------------------
    // Prescale ratio selection
    // -----------------------------------------------------------
    typedef enum logic [1:0] {
        SBRG_DIV4  = 2'b00,
        SBRG_DIV16 = 2'b01,
        SBRG_DIV64 = 2'b11
    } sbrg_ratio_e;

    // -----------------------------------------------------------
    // Majority sampler state
    // -----------------------------------------------------------
    typedef struct packed {
        logic [2:0] smp;
        logic       lvl;
    } sbrg_vote_s;

endpackage

`default_nettype wire

// >>> rtl/sbrg_vote.sv
// Purpose: Majority detector on the receive line
// Assumes: rx is already synchronised to clk
// Notes:   Level updates on each sample strobe
`include "sbrg_defs.svh"
`default_nettype none

module sbrg_vote
    import sbrg_pkg::*;
(
    input  wire logic clk,    // System clock
    input  wire logic nrst,   // Async reset, active low
    input  wire logic sample, // Sample strobe
    input  wire logic rx,     // Synchronised receive line
    output logic      level   // Majority level
);

    sbrg_vote_s s_r;
    sbrg_vote_s s_nxt;
    logic [2:0] win;

    always_comb begin
        s_nxt = s_r;
        win   = {s_r.smp[1:0], rx};
        if (sample) begin
            s_nxt.smp = win;
            // Two of three decide
            s_nxt.lvl = (win[0] & win[1]) | (win[1] & win[2]) |
                        (win[0] & win[2]);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{smp: {3{`SBRG_RX_IDLE}}, lvl: `SBRG_RX_IDLE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.lvl;

endmodule

`default_nettype wire

// >>> rtl/sbrg_divider.sv
// Purpose: Free-running divider with selectable prescale
// Assumes: Runs on the system clock only
// Notes:   sub_tick every n+1 cycles, bit_tick every ratio of them
`include "sbrg_defs.svh"
`default_nettype none

module sbrg_divider
    import sbrg_pkg::*;
#(
    parameter int CNT_W = `SBRG_CNT_W
)
(
    input  wire logic             clk,      // System clock
    input  wire logic             nrst,     // Async reset, active low
    input  wire logic             clear,    // Restart counting
    input  wire logic [CNT_W-1:0] divisor,  // Divisor n
    input  wire sbrg_ratio_e      ratio,    // Prescale ratio
    output logic      [CNT_W-1:0] count,    // Current count
    output logic                  sub_tick, // Pulse per n+1 cycles
    output logic                  bit_tick  // Pulse per bit period
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [5:0]       pre;
        logic             sub;
        logic             bt;
    } sbrg_div_s;

    sbrg_div_s s_r;
    sbrg_div_s s_nxt;

    function automatic logic [5:0] term_of(input sbrg_ratio_e r);
        unique case (r)
            SBRG_DIV4:  term_of = `SBRG_TERM_4;
            SBRG_DIV16: term_of = `SBRG_TERM_16;
            SBRG_DIV64: term_of = `SBRG_TERM_64;
            default:    term_of = `SBRG_TERM_64;
        endcase
    endfunction

    always_comb begin
        s_nxt     = s_r;
        s_nxt.sub = 1'b0;
        s_nxt.bt  = 1'b0;
        if (clear) begin
            s_nxt.cnt = '0;
            s_nxt.pre = '0;
        end else if (s_r.cnt >= divisor) begin
            // Wrap also catches a divisor lowered mid-period
            s_nxt.cnt = '0;
            s_nxt.sub = 1'b1;
            if (s_r.pre >= term_of(ratio)) begin
                s_nxt.pre = '0;
                s_nxt.bt  = 1'b1;
            end else begin
                s_nxt.pre = s_r.pre + 6'h01;
            end
        end else begin
            s_nxt.cnt = s_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count    = s_r.cnt;
    assign sub_tick = s_r.sub;
    assign bit_tick = s_r.bt;

endmodule

`default_nettype wire

// >>> tb/sbrg_top_asserts.sv
// Purpose: Port assertions of the bit-rate generator
// Assumes: Mode bits shadowed from completed bus writes
// Notes:   Tick intervals near a write are not judged
`include "sbrg_defs.svh"
`default_nettype none

module sbrg_top_asserts #(
    parameter int ADDR_W = 8,
    parameter int CNT_W  = 16
)
(
    input wire logic              clk,      // Clock
    input wire logic              nrst,     // Reset
    input wire logic [ADDR_W-1:0] awaddr,   // Address
    input wire logic              awvalid,  // Valid
    input wire logic              awready,  // Ready
    input wire logic [31:0]       wdata,    // Data
    input wire logic              wvalid,   // Valid
    input wire logic              wready,   // Ready
    input wire logic [1:0]        bresp,    // Response
    input wire logic              bvalid,   // Valid
    input wire logic              bready,   // Ready
    input wire logic              rx_level, // Voted level
    input wire logic              bit_tick, // Bit pulse
    input wire logic              sub_tick, // Divider pulse
    input wire logic              sync_mode // Sync mode
);
    logic [ADDR_W-1:0] a_q;
    logic [7:0]        d_q, hi_q, lo_q, sc_q, ns;
    logic              hs_q, wd_q, f_q, g_q, busy, tk;
    logic [2:0]        bv_q;
    logic [16:0]       cyc_q, n;

    assign busy = bvalid | (|bv_q);
    assign n    = wd_q ? {1'b0, hi_q, lo_q} : {9'h000, lo_q};
    assign tk   = bit_tick && g_q && !busy;
    assign ns   = sc_q + {7'h00, sub_tick};

    // -----------------------------------------------------------
    // Shadow of mode and divisor, interval counters
    // -----------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            a_q   <= '0;
            d_q   <= '0;
            hi_q  <= '0;
            lo_q  <= '0;
            hs_q  <= 1'b0;
            wd_q  <= 1'b0;
            f_q   <= 1'b0;
            g_q   <= 1'b0;
            bv_q  <= '0;
            cyc_q <= '0;
            sc_q  <= '0;
        end else begin
            if (awvalid && awready)
                a_q <= awaddr;
            if (wvalid && wready)
                d_q <= wdata[7:0];
            if (bvalid && bready && bresp == `SBRG_RESP_OKAY) begin
                case (a_q)
                    `SBRG_OFF_TSC:    hs_q <= d_q[`SBRG_BIT_HSPS];
                    `SBRG_OFF_RCTL:   wd_q <= d_q[`SBRG_BIT_WIDE];
                    `SBRG_OFF_DIV_HI: hi_q <= d_q;
                    `SBRG_OFF_DIV_LO: lo_q <= d_q;
                    default: ;
                endcase
            end
            bv_q  <= {bv_q[1:0], bvalid};
            f_q   <= !busy && (f_q || sub_tick);
            g_q   <= !busy && (g_q || bit_tick);
            cyc_q <= sub_tick ? 17'h0_0001 : cyc_q + 17'h0_0001;
            sc_q  <= bit_tick ? 8'h00 : ns;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_sub_period;
        sub_tick && f_q && !busy |-> cyc_q == n + 17'h0_0001;
    endproperty
    a_sub_period: assert property (p_sub_period)
        else $error("divider period differs from divisor");
    property p_ratio_64;
        tk && !sync_mode && !wd_q && !hs_q |-> ns == 8'h40;
    endproperty
    a_ratio_64: assert property (p_ratio_64)
        else $error("slow async ratio wrong");
    property p_ratio_16;
        tk && !sync_mode && (wd_q ^ hs_q) |-> ns == 8'h10;
    endproperty
    a_ratio_16: assert property (p_ratio_16)
        else $error("mid async ratio wrong");
    property p_ratio_4a;
        tk && !sync_mode && wd_q && hs_q |-> ns == 8'h04;
    endproperty
    a_ratio_4a: assert property (p_ratio_4a)
        else $error("fast async ratio wrong");
    property p_ratio_sync;
        tk && sync_mode |-> ns == 8'h04;
    endproperty
    a_ratio_sync: assert property (p_ratio_sync)
        else $error("sync ratio wrong");
    property p_sync_hs;
        tk && sync_mode && hs_q |-> ns == 8'h04;
    endproperty
    a_sync_hs: assert property (p_sync_hs)
        else $error("sync ratio follows prescale select");
    property p_level_on_tick;
        $changed(rx_level) |-> $past(sub_tick) || $past(sub_tick, 2);
    endproperty
    a_level_on_tick: assert property (p_level_on_tick)
        else $error("level changed without sample");
    property p_tick_align;
        bit_tick |-> sub_tick || $past(sub_tick);
    endproperty
    a_tick_align: assert property (p_tick_align)
        else $error("bit pulse not on divider pulse");
endmodule

bind sbrg_top sbrg_top_asserts #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_chk (
    .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .rx_level(rx_level), .bit_tick(bit_tick), .sub_tick(sub_tick),
    .sync_mode(sync_mode)
);

`default_nettype wire

// >>> tb/sbrg_top_tb.sv
// Purpose: Self-checking bench of the bit-rate generator
// Assumes: Registers at the byte offsets of the constants header
// Notes:   Mode rows in a table, edge cases by hand afterwards
`include "sbrg_defs.svh"
`default_nettype none

module sbrg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [7:0] tsc;
        logic [7:0] rctl;
        logic [7:0] hi;
        logic [7:0] lo;
        int         per;
    } sbrg_row_s;

    logic        clk, nrst, rx_pin, rx_level, bit_tick, sub_tick, sync_mode;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, ok;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    int          n_fail = 0;
    int          check_count = 0;
    int          p;
    sbrg_row_s   rows [8] = '{'{8'h00, 8'h00, 8'h05, 8'h02, 192},
        '{8'h04, 8'h00, 8'h00, 8'h03, 64}, '{8'h00, 8'h08, 8'h01, 8'h02, 4144},
        '{8'h04, 8'h08, 8'h00, 8'h09, 40}, '{8'h10, 8'h00, 8'h07, 8'h05, 24},
        '{8'h14, 8'h00, 8'h00, 8'h05, 24}, '{8'h10, 8'h08, 8'h01, 8'h00, 1028},
        '{8'h14, 8'h08, 8'h00, 8'h00, 4}};
    logic [7:0]  offs [5] = '{`SBRG_OFF_TSC, `SBRG_OFF_RSC, `SBRG_OFF_RCTL,
                              `SBRG_OFF_DIV_HI, `SBRG_OFF_DIV_LO};
    logic [7:0]  rst_v [5] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00};
    logic [7:0]  ff_v [5] = '{8'hFF, 8'hF8, 8'hDB, 8'hFF, 8'hFF};

    sbrg_top u_dut (
        .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rx_pin(rx_pin), .rx_level(rx_level), .bit_tick(bit_tick),
        .sub_tick(sub_tick), .sync_mode(sync_mode)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // -----------------------------------------------------------
    // Bus and check tasks
    // -----------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr  <= a;
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid);
        rd_v = rdata;
        rs = rresp;
    endtask

    task automatic per(output int q);
        q = 0;
        do @(posedge clk); while (!bit_tick);
        do begin
            @(posedge clk);
            q++;
        end while (!bit_tick);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        summarize();
    end

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'h1;
        rx_pin = 1'b1;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            wr(`SBRG_OFF_TSC, rows[i].tsc);
            wr(`SBRG_OFF_RCTL, rows[i].rctl);
            wr(`SBRG_OFF_DIV_HI, rows[i].hi);
            wr(`SBRG_OFF_DIV_LO, rows[i].lo);
            chk(sync_mode, rows[i].tsc[4], "sync_mode");
            repeat (4) @(posedge clk);
            per(p);
            chk(p, rows[i].per, "period");
        end
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (offs[i]) begin
            rd(offs[i]);
            chk(rd_v, {24'h00_0000, rst_v[i]}, "reset value");
            wr(offs[i], 8'hFF);
            rd(offs[i]);
            chk(rd_v, {24'h00_0000, ff_v[i]}, "access");
        end
        for (int j = 0; j < 2; j++) begin
            repeat (300) @(posedge clk);
            rd(`SBRG_OFF_STATUS);
            chk(rd_v[31:16] > 16'd200, 1'b1, "count before");
            wr(j == 0 ? `SBRG_OFF_DIV_LO : `SBRG_OFF_DIV_HI, 8'hFF);
            rd(`SBRG_OFF_STATUS);
            chk(rd_v[31:16] <= 16'd8, 1'b1, "count cleared");
        end
        wr(`SBRG_OFF_RCTL, 8'h00);
        wr(`SBRG_OFF_DIV_LO, 8'h00);
        for (int k = 1; k <= 3; k++) begin
            rx_pin <= 1'b0;
            repeat (k) @(posedge clk);
            rx_pin <= 1'b1;
            ok = 1'b1;
            repeat (10) begin
                @(posedge clk);
                ok &= rx_level;
            end
            chk(ok, k == 1, "vote held high");
        end
        rx_pin <= 1'b0;
        repeat (10) @(posedge clk);
        chk(rx_level, 1'b0, "vote low");
        wr(8'h18, 8'h55);
        chk(rs, `SBRG_RESP_SLVERR, "unmapped write resp");
        rd(8'h18);
        chk(rs, `SBRG_RESP_SLVERR, "unmapped read resp");
        chk(rd_v, 32'h0000_0000, "unmapped read data");
        summarize();
    end
endmodule

`default_nettype wire
